// ---- pic_top.sv ----
// Priority interrupt controller: flags, enables, poll and hardware call.
// Assumes the core holds pc pushes and flag writes as told and that flag
// sources give one-clock set pulses.
`timescale 1ns/1ps
module pic_top (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire pic_pkg::pic_core_t   core,
  input  wire logic                 ext_request_a_pin,
  input  wire logic                 ext_request_b_pin,
  input  wire logic                 ext_a_trigger_type,
  input  wire logic                 ext_b_trigger_type,
  input  wire logic                 timer_a_overflow,
  input  wire logic                 timer_b_overflow,
  input  wire logic                 watchdog_timeout,
  input  wire logic                 serial_receive_set,
  input  wire logic                 serial_transmit_set,
  input  wire logic                 conversion_done,
  input  wire logic                 comparator_a_out,
  input  wire logic                 comparator_b_out,
  input  wire logic                 i2c_event,
  input  wire logic                 keyboard_event,
  input  wire logic                 brownout_event,
  input  wire logic                 pwm_brake_pin,
  input  wire pic_pkg::pic_flag_wr_t flag_wr,
  input  wire logic                 serial_wr,
  input  wire logic [1:0]           serial_wr_value,
  input  wire logic                 global_irq_enable,
  input  wire logic [12:0]          source_enable,
  input  wire logic [12:0]          priority_high_bits,
  input  wire logic [12:0]          priority_low_bits,
  output pic_pkg::pic_call_t        call,
  output logic                      call_busy,
  output logic [12:0]               flags,
  output logic                      serial_receive_flag,
  output logic                      serial_transmit_flag,
  output logic [3:0]                in_service
);
  logic [12:0]        next_flags;
  logic               serial_receive;
  logic               serial_transmit;
  logic               next_serial_receive;
  logic               next_serial_transmit;
  logic [1:0]         ext_sample;
  logic [1:0]         next_ext_sample;
  logic [1:0]         comp_prev;
  logic [1:0]         next_comp_prev;
  logic               brake_prev;
  logic               next_brake_prev;
  logic [3:0]         next_in_service;
  pic_pkg::pic_state_t state;
  pic_pkg::pic_state_t next_state;
  logic [1:0]         call_count;
  logic [1:0]         next_call_count;
  pic_pkg::pic_call_t next_call;
  logic               next_call_busy;
  logic [12:0]        raw;
  logic [12:0]        pending;
  logic               found;
  logic [3:0]         winner;
  logic [1:0]         win_level;
  logic               vector_now;
  logic [3:0]         blocking;
  logic [2:0]         mc_seen;
  logic [2:0]         next_mc_seen;

  function automatic logic [15:0] vector_of(input logic [3:0] src);
    case (src)
      pic_pkg::SRC_EXT_A:     vector_of = pic_pkg::VEC_EXT_A;
      pic_pkg::SRC_BROWNOUT:  vector_of = pic_pkg::VEC_BROWNOUT;
      pic_pkg::SRC_WATCHDOG:  vector_of = pic_pkg::VEC_WATCHDOG;
      pic_pkg::SRC_TIMER_A:   vector_of = pic_pkg::VEC_TIMER_A;
      pic_pkg::SRC_I2C:       vector_of = pic_pkg::VEC_I2C;
      pic_pkg::SRC_CONVERTER: vector_of = pic_pkg::VEC_CONVERTER;
      pic_pkg::SRC_EXT_B:     vector_of = pic_pkg::VEC_EXT_B;
      pic_pkg::SRC_KEYBOARD:  vector_of = pic_pkg::VEC_KEYBOARD;
      pic_pkg::SRC_COMP_A:    vector_of = pic_pkg::VEC_COMP_A;
      pic_pkg::SRC_TIMER_B:   vector_of = pic_pkg::VEC_TIMER_B;
      pic_pkg::SRC_COMP_B:    vector_of = pic_pkg::VEC_COMP_B;
      pic_pkg::SRC_SERIAL:    vector_of = pic_pkg::VEC_SERIAL;
      default:                vector_of = pic_pkg::VEC_BRAKE;
    endcase
  endfunction

  // Sources whose flag hardware clears on vectoring
  function automatic logic auto_clears(input logic [3:0] src, input logic ext_a_edge, input logic ext_b_edge);
    case (src)
      pic_pkg::SRC_EXT_A:   auto_clears = ext_a_edge;
      pic_pkg::SRC_EXT_B:   auto_clears = ext_b_edge;
      pic_pkg::SRC_TIMER_A: auto_clears = 1'b1;
      pic_pkg::SRC_TIMER_B: auto_clears = 1'b1;
      default:              auto_clears = 1'b0;
    endcase
  endfunction

  // [R9] Both serial flags feed one source
  // [R1] Level mode requests straight from a low pin
  always_comb begin
    raw = flags;
    raw[pic_pkg::SRC_SERIAL] = serial_receive | serial_transmit;
    if (!ext_a_trigger_type) begin
      raw[pic_pkg::SRC_EXT_A] = ~ext_request_a_pin;
    end
    if (!ext_b_trigger_type) begin
      raw[pic_pkg::SRC_EXT_B] = ~ext_request_b_pin;
    end
  end

  // [R11] Individual and global enables
  assign pending = (global_irq_enable && state == pic_pkg::PIC_IDLE) ? (raw & source_enable) : 13'h0000;

  // [R23] Levels from high and low bits
  pic_arbiter u_arbiter (
    .pending   (pending),
    .prio_high (priority_high_bits),
    .prio_low  (priority_low_bits),
    .found     (found),
    .winner    (winner),
    .level     (win_level)
  );

  // [R16] Equal or higher level in service blocks
  always_comb begin
    blocking = 4'h0;
    for (int l = 0; l < pic_pkg::LEVELS; l++) begin
      blocking[l] = (in_service >> l) != 4'h0;
    end
  end

  // [R19] [R18] [R20] Fresh poll each machine cycle
  assign vector_now = core.mcycle && found && !blocking[win_level] && core.last_cycle &&
                      !core.writes_ctrl && !core.return_from_interrupt;

  // Flag state
  always_comb begin
    next_flags = flags;
    next_serial_receive = serial_receive;
    next_serial_transmit = serial_transmit;
    next_ext_sample = ext_sample;
    next_comp_prev = {comparator_b_out, comparator_a_out};
    next_brake_prev = pwm_brake_pin;
    // [R10] Software write first, hardware sets win
    next_flags = (flags & ~flag_wr.mask) | (flag_wr.value & flag_wr.mask);
    if (serial_wr) begin
      next_serial_receive = serial_wr_value[0];
      next_serial_transmit = serial_wr_value[1];
    end
    // [R4] [R5] [R7] Hardware clear on vectoring
    if (vector_now && auto_clears(winner, ext_a_trigger_type, ext_b_trigger_type)) begin
      next_flags[winner] = 1'b0;
    end
    // [R2] Edge detect at machine-cycle sampling
    if (core.mcycle) begin
      next_ext_sample = {ext_request_b_pin, ext_request_a_pin};
      if (ext_a_trigger_type && ext_sample[0] && !ext_request_a_pin) begin
        next_flags[pic_pkg::SRC_EXT_A] = 1'b1;
      end
      if (ext_b_trigger_type && ext_sample[1] && !ext_request_b_pin) begin
        next_flags[pic_pkg::SRC_EXT_B] = 1'b1;
      end
    end
    // [R7] [R8] [R12] [R14] Peripheral flag sets
    if (timer_a_overflow) next_flags[pic_pkg::SRC_TIMER_A] = 1'b1;
    if (timer_b_overflow) next_flags[pic_pkg::SRC_TIMER_B] = 1'b1;
    if (watchdog_timeout) next_flags[pic_pkg::SRC_WATCHDOG] = 1'b1;
    if (conversion_done) next_flags[pic_pkg::SRC_CONVERTER] = 1'b1;
    if (i2c_event) next_flags[pic_pkg::SRC_I2C] = 1'b1;
    if (keyboard_event) next_flags[pic_pkg::SRC_KEYBOARD] = 1'b1;
    if (brownout_event) next_flags[pic_pkg::SRC_BROWNOUT] = 1'b1;
    // [R13] Comparator toggles
    if (comparator_a_out != comp_prev[0]) next_flags[pic_pkg::SRC_COMP_A] = 1'b1;
    if (comparator_b_out != comp_prev[1]) next_flags[pic_pkg::SRC_COMP_B] = 1'b1;
    // [R15] Brake on falling brake pin
    if (brake_prev && !pwm_brake_pin) next_flags[pic_pkg::SRC_BRAKE] = 1'b1;
    // [R9] Serial flags set by hardware events or a software write, never hardware-cleared
    if (serial_receive_set) next_serial_receive = 1'b1;
    if (serial_transmit_set) next_serial_transmit = 1'b1;
    next_flags[pic_pkg::SRC_SERIAL] = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      flags <= pic_pkg::FLAGS_RESET;
      serial_receive <= 1'b0;
      serial_transmit <= 1'b0;
      serial_receive_flag <= 1'b0;
      serial_transmit_flag <= 1'b0;
      ext_sample <= 2'h3;
      // Track the live outputs so a level held across reset is no toggle
      comp_prev <= {comparator_b_out, comparator_a_out};
      brake_prev <= 1'b1;
    end else begin
      flags <= next_flags;
      serial_receive <= next_serial_receive;
      serial_transmit <= next_serial_transmit;
      serial_receive_flag <= next_serial_receive;
      serial_transmit_flag <= next_serial_transmit;
      ext_sample <= next_ext_sample;
      comp_prev <= next_comp_prev;
      brake_prev <= next_brake_prev;
    end
  end

  // Call sequencer and in-service markers
  always_comb begin
    next_state = state;
    next_call_count = call_count;
    next_in_service = in_service;
    next_call = '0;
    next_call.vector = call.vector;
    next_call.source = call.source;
    next_call_busy = call_busy;
    next_mc_seen = call_busy ? mc_seen + 3'(core.mcycle) : 3'h0;
    case (state)
      pic_pkg::PIC_IDLE: begin
        if (vector_now) begin
          // [R21] [R22] Push PC, load vector
          next_call.req = 1'b1;
          next_call.push_pc = 1'b1;
          next_call.vector = vector_of(winner);
          next_call.source = winner;
          // [R26] Mark level in service
          next_in_service[win_level] = 1'b1;
          // [R25] Four machine cycles
          next_call_count = pic_pkg::CALL_MCYCLES;
          next_call_busy = 1'b1;
          next_state = pic_pkg::PIC_CALL;
        end else if (core.mcycle && core.return_from_interrupt && core.last_cycle) begin
          // [R24] [R26] Clear highest marker on return
          for (int l = 0; l < pic_pkg::LEVELS; l++) begin
            if (in_service[l] && (in_service >> (l + 1)) == 4'h0) begin
              next_in_service[l] = 1'b0;
            end
          end
        end
      end
      pic_pkg::PIC_CALL: begin
        if (core.mcycle) begin
          next_call_count = call_count - 2'h1;
          if (call_count == 2'h1) begin
            next_state = pic_pkg::PIC_LAST;
          end
        end
      end
      pic_pkg::PIC_LAST: begin
        if (core.mcycle) begin
          next_call_count = 2'h0;
          next_call_busy = 1'b0;
          next_state = pic_pkg::PIC_IDLE;
        end
      end
      default: begin
        next_state = pic_pkg::PIC_IDLE;
        next_call_busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= pic_pkg::PIC_IDLE;
      call_count <= 2'h0;
      in_service <= pic_pkg::IN_SERVICE_RESET;
      call <= '0;
      call_busy <= 1'b0;
      mc_seen <= 3'h0;
    end else begin
      state <= next_state;
      call_count <= next_call_count;
      in_service <= next_in_service;
      call <= next_call;
      call_busy <= next_call_busy;
      mc_seen <= next_mc_seen;
    end
  end

  property p_edge_set; // [R2]
    @(posedge clk) disable iff (!reset_n)
      (core.mcycle && ext_a_trigger_type && ext_sample[0] && !ext_request_a_pin) |=> flags[pic_pkg::SRC_EXT_A];
  endproperty
  a_edge_set: assert property (p_edge_set) else $error("edge on external pin a not flagged");

  property p_timer_clear; // [R7]
    @(posedge clk) disable iff (!reset_n)
      (vector_now && winner == pic_pkg::SRC_TIMER_A && !timer_a_overflow && !flag_wr.mask[3])
        |=> !flags[pic_pkg::SRC_TIMER_A];
  endproperty
  a_timer_clear: assert property (p_timer_clear) else $error("timer flag kept after vectoring");

  property p_level_keep; // [R5]
    @(posedge clk) disable iff (!reset_n)
      (vector_now && winner == pic_pkg::SRC_EXT_B && !ext_b_trigger_type && flags[6] && !flag_wr.mask[6])
        |=> flags[pic_pkg::SRC_EXT_B];
  endproperty
  a_level_keep: assert property (p_level_keep) else $error("level flag cleared by vectoring");

  property p_global_off; // [R11]
    @(posedge clk) disable iff (!reset_n) !global_irq_enable |=> !call.req;
  endproperty
  a_global_off: assert property (p_global_off) else $error("call with global enable off");

  property p_vector; // [R22]
    @(posedge clk) disable iff (!reset_n)
      (vector_now && winner == pic_pkg::SRC_WATCHDOG) |=> (call.req && call.vector == 16'h0053);
  endproperty
  a_vector: assert property (p_vector) else $error("wrong watchdog vector");

  property p_call_len; // [R25]
    @(posedge clk) disable iff (!reset_n)
      $fell(call_busy) |-> mc_seen == 3'(pic_pkg::CALL_MCYCLES) + 3'h1;
  endproperty
  a_call_len: assert property (p_call_len) else $error("hardware call not four machine cycles long");

  property p_no_preempt; // [R16]
    @(posedge clk) disable iff (!reset_n) vector_now |-> (in_service >> win_level) == 4'h0;
  endproperty
  a_no_preempt: assert property (p_no_preempt) else $error("equal or higher level preempted");

  property p_conditions; // [R19]
    @(posedge clk) disable iff (!reset_n)
      (core.writes_ctrl || core.return_from_interrupt || !core.last_cycle) |=> !call.req;
  endproperty
  a_conditions: assert property (p_conditions) else $error("call in a denied cycle");

  property p_mark; // [R26]
    @(posedge clk) disable iff (!reset_n) vector_now |=> in_service[$past(win_level)];
  endproperty
  a_mark: assert property (p_mark) else $error("in-service marker not set");
endmodule

// ---- pic_pkg.sv ----
// Package for the priority interrupt controller: source indices, vectors,
// priority encoding and hardware-call timing.
// Assumes a core that supplies a machine-cycle strobe and instruction status.
// Behaviour
// [R1] Each external pin has own trigger-type bit
// [R2] Edge mode: high then low sample sets flag
// [R3] Requester holds each level one machine cycle
// [R4] Edge external flag cleared on vectoring
// [R5] Level external flag not cleared on vectoring
// [R6] Level requester holds pin low until serviced
// [R7] Timer overflow flags cleared on vectoring
// [R8] Watchdog flag set; enable gates; software clears
// [R9] Serial receive/transmit share one source, never hardware-cleared
// [R10] All flags writable by software
// [R11] Individual enables plus global enable
// [R12] Conversion-done flag set; software clears
// [R13] Comparator toggle sets flag; software clears
// [R14] I2C event flag set; software clears
// [R15] PWM brake sets flag; software clears
// [R16] Four levels; lower never preempts higher
// [R17] Fixed rank resolves same-level requests
// [R18] Flags sampled and polled every machine cycle
// [R19] Vector only when three conditions hold
// [R20] Requests not remembered beyond a poll
// [R21] Call pushes PC only, loads vector
// [R22] Fixed vector address per source
// [R23] High and low bits form level
// [R24] Only return-from-interrupt ends service
// [R25] Hardware call lasts four machine cycles
// [R26] One in-service marker per level
package pic_pkg;
  localparam int NSRC = 13;
  localparam int LEVELS = 4;

  // Source index equals arbitration rank minus one, so index 0 wins a tie
  localparam logic [3:0] SRC_EXT_A = 4'h0;
  localparam logic [3:0] SRC_BROWNOUT = 4'h1;
  localparam logic [3:0] SRC_WATCHDOG = 4'h2;
  localparam logic [3:0] SRC_TIMER_A = 4'h3;
  localparam logic [3:0] SRC_I2C = 4'h4;
  localparam logic [3:0] SRC_CONVERTER = 4'h5;
  localparam logic [3:0] SRC_EXT_B = 4'h6;
  localparam logic [3:0] SRC_KEYBOARD = 4'h7;
  localparam logic [3:0] SRC_COMP_A = 4'h8;
  localparam logic [3:0] SRC_TIMER_B = 4'h9;
  localparam logic [3:0] SRC_COMP_B = 4'ha;
  localparam logic [3:0] SRC_SERIAL = 4'hb;
  localparam logic [3:0] SRC_BRAKE = 4'hc;

  localparam logic [15:0] VEC_EXT_A = 16'h0003;
  localparam logic [15:0] VEC_TIMER_A = 16'h000b;
  localparam logic [15:0] VEC_EXT_B = 16'h0013;
  localparam logic [15:0] VEC_TIMER_B = 16'h001b;
  localparam logic [15:0] VEC_SERIAL = 16'h0023;
  localparam logic [15:0] VEC_BROWNOUT = 16'h002b;
  localparam logic [15:0] VEC_I2C = 16'h0033;
  localparam logic [15:0] VEC_KEYBOARD = 16'h003b;
  localparam logic [15:0] VEC_COMP_B = 16'h0043;
  localparam logic [15:0] VEC_WATCHDOG = 16'h0053;
  localparam logic [15:0] VEC_CONVERTER = 16'h005b;
  localparam logic [15:0] VEC_COMP_A = 16'h0063;
  localparam logic [15:0] VEC_BRAKE = 16'h0073;

  localparam logic [1:0] CALL_MCYCLES = 2'h3;  // Four machine cycles, counted 3..0
  localparam logic [12:0] FLAGS_RESET = 13'h0000;
  localparam logic [12:0] ENABLES_RESET = 13'h0000;
  localparam logic [3:0] IN_SERVICE_RESET = 4'h0;

  typedef enum logic [1:0] {
    PIC_IDLE = 2'b00,
    PIC_CALL = 2'b01,
    PIC_LAST = 2'b11
  } pic_state_t;

  // Instruction status from the core sequencer, valid with the machine-cycle strobe
  typedef struct packed {
    logic mcycle;       // One-clock strobe at each machine-cycle boundary
    logic last_cycle;   // Current machine cycle is the instruction's last
    logic writes_ctrl;  // Instruction writes an enable or priority register
    logic return_from_interrupt;  // Instruction ends a service routine
  } pic_core_t;

  // Software write to a flag: mask selects flags, value is written
  typedef struct packed {
    logic [12:0] mask;
    logic [12:0] value;
  } pic_flag_wr_t;

  typedef struct packed {
    logic        req;     // One-clock pulse: begin long_subroutine_call
    logic [15:0] vector;
    logic [3:0]  source;
    logic        push_pc;  // Push program counter only, no status word
  } pic_call_t;
endpackage

// ---- pic_arbiter.sv ----
// Combinational poll: finds the highest level, then the best rank within it.
// Assumes pending requests are already gated by all enables.
`timescale 1ns/1ps
module pic_arbiter (
  input  wire logic [12:0] pending,
  input  wire logic [12:0] prio_high,
  input  wire logic [12:0] prio_low,
  output logic             found,
  output logic [3:0]       winner,
  output logic [1:0]       level
);
  always_comb begin
    found = 1'b0;
    winner = 4'h0;
    level = 2'h0;
    // [R16] [R17] Level first, rank second
    for (int l = 3; l >= 0; l--) begin
      for (int s = pic_pkg::NSRC - 1; s >= 0; s--) begin
        if (!found || level == 2'(l)) begin
          if (pending[s] && {prio_high[s], prio_low[s]} == 2'(l) && (!found || 4'(s) < winner)) begin
            found = 1'b1;
            winner = 4'(s);
            level = 2'(l);
          end
        end
      end
    end
  end
endmodule

// ---- pic_core_model.sv ----
// Core sequencer model: machine-cycle strobe every fourth clock plus instruction status.
// Assumes the bench asks for return_from_interrupt with a one-clock pulse.
`timescale 1ns/1ps
module pic_core_model (
  input  wire logic          clk,
  input  wire logic          reset_n,
  input  wire logic          last_en,
  input  wire logic          wr_ctrl,
  input  wire logic          ret_req,
  output pic_pkg::pic_core_t core
);
  logic [1:0] phase;
  logic [1:0] next_phase;
  logic       ret_pend;
  logic       next_ret_pend;

  always_comb begin
    next_phase    = reset_n ? phase + 2'h1 : 2'h0;
    next_ret_pend = reset_n & (ret_req | (ret_pend & (phase != 2'h3)));
  end

  always_ff @(posedge clk) begin
    phase    <= next_phase;
    ret_pend <= next_ret_pend;
  end

  // status is only meaningful with the strobe, so it carries junk between
  always_comb begin
    core.mcycle      = (phase == 2'h3);
    core.last_cycle  = (phase == 2'h3) ? (last_en | ret_pend) : ~last_en;
    core.writes_ctrl = (phase == 2'h3) ? wr_ctrl : ~wr_ctrl;
    core.return_from_interrupt = (phase == 2'h3) ? ret_pend : ~ret_pend;
  end
endmodule

// ---- pic_top_tb.sv ----
// Self-checking bench for the interrupt controller, driven through a core model.
// Assumes a 100 MHz clock and a machine cycle of four clocks.
`timescale 1ns/1ps
module pic_top_tb;
  logic                  clk = 1'b0, reset_n = 1'b0;
  logic                  pin_a = 1'b1, pin_b = 1'b1, trig_a = 1'b1, trig_b = 1'b1;
  logic [6:0]            ev = 7'h00;
  logic [1:0]            ser_set = 2'h0, ser_val = 2'h0;
  logic                  cmp_a = 1'b0, cmp_b = 1'b0, brake = 1'b1, ser_wr = 1'b0, gie = 1'b0;
  pic_pkg::pic_flag_wr_t fw = '0;
  logic [12:0]           en = 13'h0000, ph = 13'h0000, pl = 13'h0000;
  logic                  last_en = 1'b0, wr_ctrl = 1'b0, ret_req = 1'b0;
  pic_pkg::pic_core_t    core;
  pic_pkg::pic_call_t    call;
  logic                  busy, rx_flag, tx_flag;
  logic [12:0]           flags;
  logic [3:0]            in_svc;
  int                    mismatches = 0;
  int                    n_tests = 0;

  pic_core_model i_core (.clk(clk), .reset_n(reset_n), .last_en(last_en), .wr_ctrl(wr_ctrl),
    .ret_req(ret_req), .core(core));

  pic_top i_dut (.clk(clk), .reset_n(reset_n), .core(core), .ext_request_a_pin(pin_a),
    .ext_request_b_pin(pin_b), .ext_a_trigger_type(trig_a), .ext_b_trigger_type(trig_b),
    .timer_a_overflow(ev[0]), .timer_b_overflow(ev[1]), .watchdog_timeout(ev[2]),
    .conversion_done(ev[3]), .i2c_event(ev[4]), .keyboard_event(ev[5]), .brownout_event(ev[6]),
    .serial_receive_set(ser_set[0]), .serial_transmit_set(ser_set[1]), .comparator_a_out(cmp_a),
    .comparator_b_out(cmp_b), .pwm_brake_pin(brake), .flag_wr(fw), .serial_wr(ser_wr),
    .serial_wr_value(ser_val), .global_irq_enable(gie), .source_enable(en), .priority_high_bits(ph),
    .priority_low_bits(pl), .call(call), .call_busy(busy), .flags(flags),
    .serial_receive_flag(rx_flag), .serial_transmit_flag(tx_flag), .in_service(in_svc));

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic clocks(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic sw_flags(input logic [12:0] m, input logic [12:0] v);
    @(posedge clk);
    fw <= '{mask: m, value: v};
    @(posedge clk);
    fw <= '0;
    clocks(1);
  endtask

  task automatic sw_serial(input logic [1:0] v);
    @(posedge clk);
    ser_wr  <= 1'b1;
    ser_val <= v;
    @(posedge clk);
    ser_wr <= 1'b0;
    clocks(1);
  endtask

  task automatic isr_return();
    @(posedge clk);
    ret_req <= 1'b1;
    @(posedge clk);
    ret_req <= 1'b0;
    clocks(10);
  endtask

  task automatic wait_call(input int lim, output logic got);
    got = 1'b0;
    for (int i = 0; i < lim && got == 1'b0; i++) begin
      @(posedge clk);
      #1;
      got = (call.req === 1'b1);
    end
  endtask

  // Caller raises last_en itself when the poll should be allowed
  task automatic no_call();
    logic got;
    wait_call(40, got);
    chk(16'(got), 16'h0000);
  endtask

  // Opens one poll window, then drops it as soon as the call is seen
  task automatic expect_call(input logic [15:0] vec, input logic [3:0] src);
    logic got;
    int   n;
    @(posedge clk);
    last_en <= 1'b1;
    wait_call(64, got);
    if (got !== 1'b1) begin
      mismatches++;
      print_verdict();
    end
    chk(call.vector, vec);
    chk(16'(call.source), 16'(src));
    chk(16'(call.push_pc), 16'h0001);
    n = 1;
    while (busy === 1'b1 && n < 40) begin
      @(posedge clk);
      last_en <= 1'b0;
      #1;
      n++;
    end
    chk(16'(n), 16'h0011);
  endtask

  task automatic t_sources();
    logic [15:0] vec [13] = '{16'h0003, 16'h002b, 16'h0053, 16'h000b, 16'h0033, 16'h005b, 16'h0013,
                              16'h003b, 16'h0063, 16'h001b, 16'h0043, 16'h0023, 16'h0073};
    logic [12:0] hw_clr = 13'h0249;
    for (int i = 0; i < 13; i++) begin
      @(posedge clk);
      gie <= 1'b1;
      en  <= 13'h0001 << i;
      if (i == 11) begin
        sw_serial(2'h1);
      end else begin
        sw_flags(13'h0001 << i, 13'h1fff);
      end
      expect_call(vec[i], 4'(i));
      chk(16'(in_svc), 16'h0001);
      chk(16'(flags[i]), 16'(!hw_clr[i] && i != 11));
      chk(16'(rx_flag), 16'(i == 11));
      isr_return();
      chk(16'(in_svc), 16'h0000);
      sw_flags(13'h1fff, 13'h0000);
      sw_serial(2'h0);
    end
  endtask

  task automatic t_arbit();
    @(posedge clk);
    en <= 13'h1fff;
    ph <= 13'h1000;
    sw_flags(13'h1fff, 13'h1fff);
    sw_serial(2'h3);
    expect_call(16'h0073, 4'hc);
    chk(16'(in_svc), 16'h0004);
    @(posedge clk);
    last_en <= 1'b1;
    no_call();
    @(posedge clk);
    last_en <= 1'b0;
    ph      <= 13'h1040;
    pl      <= 13'h0040;
    expect_call(16'h0013, 4'h6);
    chk(16'(in_svc), 16'h000c);
    isr_return();
    chk(16'(in_svc), 16'h0004);
    isr_return();
    @(posedge clk);
    ph <= 13'h0000;
    pl <= 13'h0000;
    expect_call(16'h0003, 4'h0);
    @(posedge clk);
    pl <= 13'h0002;
    expect_call(16'h002b, 4'h1);
    chk(16'(in_svc), 16'h0003);
    isr_return();
    isr_return();
    sw_flags(13'h1fff, 13'h0000);
    sw_serial(2'h0);
  endtask

  task automatic t_deny();
    logic [3:0] cfg [4] = '{4'b0101, 4'b1001, 4'b1111, 4'b1100};
    @(posedge clk);
    en    <= 13'h0000;
    ev[0] <= 1'b1;
    @(posedge clk);
    ev[0] <= 1'b0;
    clocks(1);
    chk(16'(flags[3]), 16'h0001);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      {gie, en[3], wr_ctrl, last_en} <= cfg[i];
      no_call();
    end
    sw_flags(13'h0008, 13'h0000);
    @(posedge clk);
    last_en <= 1'b1;
    no_call();
    @(posedge clk);
    last_en <= 1'b0;
    ev[0]   <= 1'b1;
    @(posedge clk);
    ev[0] <= 1'b0;
    expect_call(16'h000b, 4'h3);
    chk(16'(flags[3]), 16'h0000);
    isr_return();
  endtask

  task automatic t_pins();
    // edge mode: pin held low sets the flag once; after a clear it stays clear
    @(posedge clk);
    pin_a <= 1'b0;
    clocks(8);
    chk(16'(flags[0]), 16'h0001);
    sw_flags(13'h0001, 13'h0000);
    clocks(12);
    chk(16'(flags[0]), 16'h0000);
    // level requester holds low until serviced
    @(posedge clk);
    pin_a  <= 1'b1;
    trig_b <= 1'b0;
    en     <= 13'h0040;
    pin_b  <= 1'b0;
    sw_flags(13'h0040, 13'h0040);
    expect_call(16'h0013, 4'h6);
    chk(16'(flags[6]), 16'h0001);
    isr_return();
    expect_call(16'h0013, 4'h6);
    @(posedge clk);
    pin_b <= 1'b1;
    isr_return();
    @(posedge clk);
    last_en <= 1'b1;
    no_call();
    @(posedge clk);
    last_en <= 1'b0;
    ev      <= 7'h7f;
    ser_set <= 2'h3;
    cmp_a   <= 1'b1;
    cmp_b   <= 1'b1;
    brake   <= 1'b0;
    @(posedge clk);
    ev      <= 7'h00;
    ser_set <= 2'h0;
    clocks(3);
    chk(16'(flags), 16'h17fe);
    chk(16'({rx_flag, tx_flag}), 16'h0003);
    sw_flags(13'h1fff, 13'h0000);
    sw_serial(2'h0);
    chk(16'(flags), 16'h0000);
    chk(16'({rx_flag, tx_flag}), 16'h0000);
  endtask

  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    clocks(1);
    chk(16'({call.req, busy, in_svc}), 16'h0000);
    chk(16'(flags), 16'h0000);
    t_sources();
    t_arbit();
    t_deny();
    t_pins();
    print_verdict();
  end
endmodule
